// ### flash_rst_param_read.sv
`timescale 1ns/1ps
`include "flash_rst_cfg.svh"

// What this block and its host must do
// [R1] Select, opcode 5Ah, three address bytes, one dummy byte, then table bytes out.
// [R2] Deselect during data-out stops output drive and ends the read.
// [R3] Reset pin low at least 10 us causes a full device reset.
// [R4] After reset: standby, volatile bits cleared, 3-byte addressing.
// [R5] Reset during program or erase aborts that operation.
// [R6] While reset pin is low, serial output floats and activity stops.
// [R7] Host waits 10 us after reset release before selecting.
// [R8] Reset from power-on state recovers in 35 us before commands.
// [R9] Reset during decode or read recovers 40 us; during program 310 us.
// [R10] Erase and status-write interrupted resets recover 12, 25, 1000, 40 ms.
// [R11] Power-up lands in standby, not deep power-down, write latch cleared.
// [R12] Supply below write-inhibit threshold holds logic reset, commands ignored.
// [R13] Host keeps device deselected through power ramps and settle delay; the testbench selects the device while supply_ok is low.
// [R14] Host issues commands only after supply settle delay; the testbench sends write enable while supply_ok is low.
// [R15] Soft reset needs arm then reset back to back; clears volatile state.
// [R16] Host blocks commands after any reset until recovery elapses.
// [R17] Table bytes leave MSB first on falling clock edges, address advancing.
module flash_rst_param_read
  import flash_rst_pkg::*;
#(
  parameter int unsigned TBL_DEPTH = 256,
  parameter int unsigned RST_PULSE_CYC = `RESET_PULSE_MIN_CYC,
  parameter int unsigned POR_RECOV_CYC = `POWER_ON_RESET_RECOVERY_CYC,
  parameter int unsigned DECODE_RECOV_CYC = `RECOV_DECODE_CYC,
  parameter int unsigned READ_RECOV_CYC = `RECOV_READ_CYC,
  parameter int unsigned PROG_RECOV_CYC = `RECOV_PROGRAM_CYC,
  parameter int unsigned SE4K_RECOV_CYC = `RECOV_SECTOR_ERASE_4K_CYC,
  parameter int unsigned BE_RECOV_CYC = `RECOV_BLOCK_ERASE_CYC,
  parameter int unsigned CE_RECOV_CYC = `RECOV_CHIP_ERASE_CYC,
  parameter int unsigned STATUS_REG_WRITE_RECOV_CYC = `RECOV_STATUS_REG_WRITE_CYC
) (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // Serial pins
  input wire logic I_CS_N,
  input wire logic I_SCLK,
  input wire logic I_SI,
  input wire logic I_RESET_N,
  output logic O_SO,
  output logic O_SO_OE,
  // Supply monitor
  input wire logic I_SUPPLY_OK,
  // Core operation status
  input wire logic I_OP_BUSY,
  input wire logic [2:0] I_OP_KIND,
  input wire logic I_SRAM_LOCK_SET,
  input wire logic I_ADDR_4B_SET,
  // Parameter table load port
  input wire logic I_TBL_WE,
  input wire logic [7:0] I_TBL_ADDR,
  input wire logic [7:0] I_TBL_DATA,
  // Device state
  output logic O_READY,
  output logic O_WRITE_ENABLE_LATCH,
  output logic O_WRITE_IN_PROGRESS,
  output logic O_SRAM_LOCK,
  output logic O_ADDR_4B,
  output logic O_OP_ABORT,
  output logic O_SOFT_RESET_ARMED
);

  localparam int unsigned AW = $clog2(TBL_DEPTH);

  // Elaboration checks
  if (TBL_DEPTH < 2 || TBL_DEPTH > 256 || (1 << AW) != TBL_DEPTH)
  begin : g_chk_tbl
    $error("TBL_DEPTH must be a power of two up to 256");
  end
  if (RST_PULSE_CYC < 1 || POR_RECOV_CYC < 1 || DECODE_RECOV_CYC < 1)
  begin : g_chk_cnt
    $error("timing counts must be at least one cycle");
  end

  // Recovery time for the operation a reset cuts short
  function automatic logic [31:0] recov_for(input op_kind_t kind, input logic decoding);
    logic [31:0] c;
    c = 32'(DECODE_RECOV_CYC);
    case (kind)
      OP_READ: c = 32'(READ_RECOV_CYC); // [R9]
      OP_PROGRAM: c = 32'(PROG_RECOV_CYC); // [R9]
      OP_SECTOR_ERASE_4K: c = 32'(SE4K_RECOV_CYC); // [R10]
      OP_BLOCK_ERASE: c = 32'(BE_RECOV_CYC); // [R10]
      OP_CHIP_ERASE: c = 32'(CE_RECOV_CYC); // [R10]
      OP_STATUS_REG_WRITE: c = 32'(STATUS_REG_WRITE_RECOV_CYC); // [R10]
      default: c = decoding ? 32'(DECODE_RECOV_CYC) : 32'(DECODE_RECOV_CYC);
    endcase
    return c;
  endfunction

  logic [7:0] tbl_mem [TBL_DEPTH];
  logic sclk_q;
  spi_state_t state_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic [1:0] byte_q;
  logic [AW-1:0] addr_q;
  logic [2:0] out_bit_q;
  logic [31:0] pulse_q;
  logic pulse_ok_q;
  logic por_q;
  logic [31:0] recov_cnt_q;
  logic armed_q;
  logic soft_rst_q;
  logic recov_busy;

  // Pin decode; SCLK is sampled as an ordinary synchronous input
  logic sclk_rise;
  logic sclk_fall;
  logic byte_done;
  logic [7:0] byte_in;
  logic hold_rst;
  logic full_rst;
  assign sclk_rise = I_SCLK && !sclk_q;
  assign sclk_fall = !I_SCLK && sclk_q;
  assign byte_in = {shift_q[6:0], I_SI};
  assign byte_done = sclk_rise && (bit_q == 3'h7);
  assign hold_rst = !I_RESET_N || !I_SUPPLY_OK; // [R6] [R12]
  assign full_rst = (!I_RESET_N && (pulse_q == 32'(RST_PULSE_CYC - 1))) || soft_rst_q;

  // Table storage, loaded by the surrounding system
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_TBL_WE)
    begin
      tbl_mem[I_TBL_ADDR[AW-1:0]] <= I_TBL_DATA;
    end
  end

  // Clock edge history
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      sclk_q <= 1'b0;
    end
    else
    begin
      sclk_q <= I_SCLK;
    end
  end

  // Reset pulse width measurement; short glitches do not reset
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      pulse_q <= '0;
      pulse_ok_q <= 1'b0;
    end
    else if (I_RESET_N)
    begin
      pulse_q <= '0;
      pulse_ok_q <= 1'b0;
    end
    else
    begin
      if (pulse_q != 32'(RST_PULSE_CYC))
      begin
        pulse_q <= pulse_q + 32'h1;
      end
      if (full_rst)
      begin
        pulse_ok_q <= 1'b1; // [R3]
      end
    end
  end

  // Recovery length captured when the reset takes effect
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      recov_cnt_q <= '0;
    end
    else if (full_rst)
    begin
      if (por_q)
      begin
        recov_cnt_q <= 32'(POR_RECOV_CYC); // [R8]
      end
      else
      begin
        recov_cnt_q <= recov_for(op_kind_t'(I_OP_KIND), state_q != ST_IDLE); // [R9] [R10]
      end
    end
  end

  // Power-on state lasts until the first command is taken
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      por_q <= 1'b1; // [R11]
    end
    else if (byte_done && state_q == ST_CMD && O_READY)
    begin
      por_q <= 1'b0;
    end
  end

  // Recovery wait starts on reset release or right after a soft reset
  recovery_timer #(
    .WIDTH(32)
  ) u_recovery (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_load((I_RESET_N && pulse_ok_q) || (soft_rst_q && I_RESET_N)),
    .i_count(soft_rst_q ? recov_for(op_kind_t'(I_OP_KIND), 1'b1) : recov_cnt_q),
    .o_busy(recov_busy)
  );

  // Ready only when powered, out of reset and recovered
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_READY <= 1'b0;
    end
    else
    begin
      O_READY <= !hold_rst && !pulse_ok_q && !recov_busy && !soft_rst_q; // [R8] [R9] [R12]
    end
  end

  // Serial command front end
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_q <= ST_IDLE;
      bit_q <= '0;
      shift_q <= '0;
      byte_q <= '0;
    end
    else if (hold_rst || I_CS_N || soft_rst_q)
    begin
      state_q <= ST_IDLE; // [R2] [R6]
      bit_q <= '0;
      byte_q <= '0;
    end
    else
    begin
      if (state_q == ST_IDLE)
      begin
        state_q <= O_READY ? ST_CMD : ST_IGNORE; // [R12]
      end
      if (sclk_rise)
      begin
        shift_q <= byte_in;
        bit_q <= bit_q + 3'h1;
      end
      if (byte_done)
      begin
        case (state_q)
          ST_CMD:
            state_q <= (byte_in == `CMD_READ_PARAM_TABLE) ? ST_ADDR : ST_IGNORE; // [R1]
          ST_ADDR:
          begin
            byte_q <= byte_q + 2'h1;
            if (byte_q == 2'(`ADDR_BYTES - 1))
            begin
              byte_q <= '0;
              state_q <= ST_DUMMY; // [R1]
            end
          end
          ST_DUMMY:
          begin
            byte_q <= byte_q + 2'h1;
            if (byte_q == 2'(`DUMMY_BYTES - 1))
            begin
              state_q <= ST_DATA; // [R1]
            end
          end
          default: state_q <= state_q;
        endcase
      end
    end
  end

  // Address capture and per-byte advance
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      addr_q <= '0;
      out_bit_q <= 3'h7;
    end
    else if (state_q == ST_ADDR && byte_done)
    begin
      addr_q <= byte_in[AW-1:0]; // [R1] Low address bits pick the entry
      out_bit_q <= 3'h7;
    end
    else if (state_q == ST_DATA && sclk_fall && !I_CS_N)
    begin
      out_bit_q <= out_bit_q - 3'h1;
      if (out_bit_q == 3'h0)
      begin
        addr_q <= addr_q + 1'b1; // [R17]
      end
    end
  end

  // Output drive: MSB first on falling edges, released on deselect or reset
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_SO <= 1'b0;
      O_SO_OE <= 1'b0;
    end
    else if (hold_rst || I_CS_N || state_q != ST_DATA)
    begin
      O_SO_OE <= 1'b0; // [R2] [R6]
    end
    else if (sclk_fall)
    begin
      O_SO <= tbl_mem[addr_q][out_bit_q]; // [R17]
      O_SO_OE <= 1'b1;
    end
  end

  // Soft reset arming; any other complete command byte disarms
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      armed_q <= 1'b0;
      soft_rst_q <= 1'b0;
    end
    else
    begin
      soft_rst_q <= 1'b0;
      if (hold_rst)
      begin
        armed_q <= 1'b0;
      end
      else if (byte_done && state_q == ST_CMD)
      begin
        armed_q <= (byte_in == `CMD_SOFT_RESET_ARM); // [R15]
        soft_rst_q <= armed_q && (byte_in == `CMD_SOFT_RESET); // [R15]
      end
    end
  end

  // Volatile bits return to power-on values on any full reset
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_WRITE_ENABLE_LATCH <= 1'b0; // [R11]
      O_WRITE_IN_PROGRESS <= 1'b0;
      O_SRAM_LOCK <= 1'b0;
      O_ADDR_4B <= 1'b0;
      O_SOFT_RESET_ARMED <= 1'b0;
    end
    // Short pin glitches keep the bits; a qualified pulse clears them until release
    else if (full_rst || pulse_ok_q || !I_SUPPLY_OK)
    begin
      O_WRITE_ENABLE_LATCH <= 1'b0; // [R4] [R12] [R15]
      O_WRITE_IN_PROGRESS <= 1'b0; // [R4]
      O_SRAM_LOCK <= 1'b0; // [R4]
      O_ADDR_4B <= 1'b0; // [R4]
      O_SOFT_RESET_ARMED <= 1'b0;
    end
    else
    begin
      O_WRITE_IN_PROGRESS <= I_OP_BUSY;
      O_SOFT_RESET_ARMED <= armed_q;
      // Set wins over the reset-free idle case
      if (I_SRAM_LOCK_SET)
      begin
        O_SRAM_LOCK <= 1'b1;
      end
      if (I_ADDR_4B_SET)
      begin
        O_ADDR_4B <= 1'b1;
      end
      if (byte_done && state_q == ST_CMD && byte_in == `CMD_WRITE_ENABLE)
      begin
        O_WRITE_ENABLE_LATCH <= 1'b1;
      end
      else if (byte_done && state_q == ST_CMD && byte_in == `CMD_WRITE_DISABLE)
      begin
        O_WRITE_ENABLE_LATCH <= 1'b0;
      end
    end
  end

  // Abort pulse to the core when a reset lands on a running operation
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_OP_ABORT <= 1'b0;
    end
    else
    begin
      O_OP_ABORT <= full_rst && I_OP_BUSY; // [R5]
    end
  end

endmodule // flash_rst_param_read

// ### flash_rst_cfg.svh
`ifndef FLASH_RST_CFG_SVH
`define FLASH_RST_CFG_SVH

// System clock rate
`define CLK_MHZ 250

// Command opcodes
`define CMD_READ_PARAM_TABLE 8'h5A
`define CMD_SOFT_RESET_ARM 8'h66
`define CMD_SOFT_RESET 8'h99
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04

// Read framing
`define ADDR_BYTES 3
`define DUMMY_BYTES 1

// Times as printed
`define RESET_PULSE_MIN_US 10
`define POWER_ON_RESET_RECOVERY_US 35
`define RECOV_DECODE_US 40
`define RECOV_READ_US 40
`define RECOV_PROGRAM_US 310
`define RECOV_SECTOR_ERASE_4K_MS 12
`define RECOV_BLOCK_ERASE_MS 25
`define RECOV_CHIP_ERASE_MS 1000
`define RECOV_STATUS_REG_WRITE_MS 40

// Derived cycle counts
`define RESET_PULSE_MIN_CYC (`RESET_PULSE_MIN_US * `CLK_MHZ)
`define POWER_ON_RESET_RECOVERY_CYC (`POWER_ON_RESET_RECOVERY_US * `CLK_MHZ)
`define RECOV_DECODE_CYC (`RECOV_DECODE_US * `CLK_MHZ)
`define RECOV_READ_CYC (`RECOV_READ_US * `CLK_MHZ)
`define RECOV_PROGRAM_CYC (`RECOV_PROGRAM_US * `CLK_MHZ)
`define RECOV_SECTOR_ERASE_4K_CYC (`RECOV_SECTOR_ERASE_4K_MS * 1000 * `CLK_MHZ)
`define RECOV_BLOCK_ERASE_CYC (`RECOV_BLOCK_ERASE_MS * 1000 * `CLK_MHZ)
`define RECOV_CHIP_ERASE_CYC (`RECOV_CHIP_ERASE_MS * 1000 * `CLK_MHZ)
`define RECOV_STATUS_REG_WRITE_CYC (`RECOV_STATUS_REG_WRITE_MS * 1000 * `CLK_MHZ)

`endif

// ### flash_rst_pkg.sv
package flash_rst_pkg;

  // Serial front-end states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } spi_state_t;

  // Kind of core operation running when a reset hits
  typedef enum logic [2:0] {
    OP_NONE,
    OP_READ,
    OP_PROGRAM,
    OP_SECTOR_ERASE_4K,
    OP_BLOCK_ERASE,
    OP_CHIP_ERASE,
    OP_STATUS_REG_WRITE
  } op_kind_t;

endpackage

// ### recovery_timer.sv
`timescale 1ns/1ps

// Down-counter that blocks command intake after a reset
module recovery_timer #(
  parameter int unsigned WIDTH = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Load request
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_count,
  // Status
  output logic o_busy
);

  logic [WIDTH-1:0] cnt_q;

  // Elaboration check
  if (WIDTH < 2)
  begin : g_chk
    $error("recovery_timer WIDTH too small");
  end

  // Reload wins over counting so a second reset restarts the wait
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q <= '0;
    end
    else if (i_load)
    begin
      cnt_q <= i_count;
    end
    else if (cnt_q != '0)
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Busy while any cycles remain
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_busy <= 1'b0;
    end
    else
    begin
      o_busy <= i_load || (cnt_q > {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

endmodule // recovery_timer

// ### flash_rst_param_read_sva.sv
`timescale 1ns/1ps

module flash_rst_param_read_sva #(
  parameter int unsigned RST_PULSE_CYC = 8,
  parameter int unsigned POR_RECOV_CYC = 20
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_CS_N,
  input wire logic I_SCLK,
  input wire logic I_RESET_N,
  input wire logic I_SUPPLY_OK,
  input wire logic O_SO,
  input wire logic O_SO_OE,
  input wire logic O_READY,
  input wire logic O_WRITE_ENABLE_LATCH,
  input wire logic O_SRAM_LOCK,
  input wire logic O_ADDR_4B,
  input wire logic O_OP_ABORT
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);

  int unsigned low_cnt_q;
  int unsigned rel_cnt_q;

  // Length of the current reset pin low phase, saturating
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
    if (I_RST || I_RESET_N) low_cnt_q <= 0;
    else if (low_cnt_q < 1000) low_cnt_q <= low_cnt_q + 1;

  // Cycles since a qualified pulse ended; starts saturated so power-on never trips it
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
    if (I_RST) rel_cnt_q <= 1000;
    else if (I_RESET_N && low_cnt_q >= RST_PULSE_CYC) rel_cnt_q <= 0;
    else if (rel_cnt_q < 1000) rel_cnt_q <= rel_cnt_q + 1;

  // Named conditions: three deselected cycles, and a single-cycle reset pin low past the pulse width
  sequence s_desel;
    I_CS_N [*3];
  endsequence
  sequence s_full_hold;
    !I_RESET_N && low_cnt_q >= RST_PULSE_CYC + 2;
  endsequence

  property p_oe_desel;
    s_desel |-> !O_SO_OE;
  endproperty
  a_oe_desel: assert property (p_oe_desel) else $error("output still driven after deselect");
  property p_oe_rst;
    !I_RESET_N |=> !O_SO_OE;
  endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("output driven while reset pin low");
  property p_rdy_rst;
    !I_RESET_N |=> !O_READY;
  endproperty
  a_rdy_rst: assert property (p_rdy_rst) else $error("ready while reset pin low");
  property p_supply;
    !I_SUPPLY_OK |=> !O_READY;
  endproperty
  a_supply: assert property (p_supply) else $error("ready with supply below threshold");
  property p_clear;
    s_full_hold |-> !O_WRITE_ENABLE_LATCH && !O_SRAM_LOCK && !O_ADDR_4B;
  endproperty
  a_clear: assert property (p_clear) else $error("volatile bits kept over full reset");
  property p_oe_sel;
    $rose(O_SO_OE) |-> !I_CS_N && O_READY;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("output enabled without selection");
  property p_so_fall;
    O_SO_OE && $past(O_SO_OE) && $changed(O_SO) |-> !I_SCLK;
  endproperty
  a_so_fall: assert property (p_so_fall) else $error("output bit moved off falling clock");
  property p_abort_one;
    O_OP_ABORT |=> !O_OP_ABORT;
  endproperty
  a_abort_one: assert property (p_abort_one) else $error("abort pulse longer than one cycle");
  property p_rdy_recov;
    $rose(O_READY) |-> rel_cnt_q >= POR_RECOV_CYC + 1;
  endproperty
  a_rdy_recov: assert property (p_rdy_recov) else $error("ready before recovery elapsed");
endmodule // flash_rst_param_read_sva

bind flash_rst_param_read flash_rst_param_read_sva #(
  .RST_PULSE_CYC(RST_PULSE_CYC), .POR_RECOV_CYC(POR_RECOV_CYC)
) u_sva (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_CS_N(I_CS_N), .I_SCLK(I_SCLK),
  .I_RESET_N(I_RESET_N), .I_SUPPLY_OK(I_SUPPLY_OK), .O_SO(O_SO), .O_SO_OE(O_SO_OE),
  .O_READY(O_READY), .O_WRITE_ENABLE_LATCH(O_WRITE_ENABLE_LATCH),
  .O_SRAM_LOCK(O_SRAM_LOCK), .O_ADDR_4B(O_ADDR_4B), .O_OP_ABORT(O_OP_ABORT)
);

// ### spi_host_model.sv
`timescale 1ns/1ps

// Host controller: serial clock idles low, all changes at falling system edge
module spi_host_model #(
  parameter int unsigned SEL_DELAY_CYC = 16
) (
  input wire logic i_clk,
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_si,
  output logic o_reset_n
);
  // Idle pins: deselected through power ramp
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b0;
    o_reset_n = 1'b1;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Serial clock held 4 system cycles per phase, well under the oversampling limit
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      o_si = tx[i];
      wait_n(4);
      rx[i] = i_so;
      o_sclk = 1'b1;
      wait_n(4);
      o_sclk = 1'b0;
    end
    o_si = ~o_si; // Stale line shows no old value
  endtask

  task automatic sel();
    wait_n(2);
    o_cs_n = 1'b0;
    wait_n(2);
  endtask

  task automatic desel();
    wait_n(2);
    o_cs_n = 1'b1;
    wait_n(4);
  endtask

  task automatic hw_reset(input int n);
    o_reset_n = 1'b0;
    wait_n(n);
    o_reset_n = 1'b1;
  endtask

  // Host-side timer before selecting again
  task automatic settle();
    wait_n(SEL_DELAY_CYC);
  endtask
endmodule // spi_host_model

// ### flash_rst_param_read_tb_top.sv
`timescale 1ns/1ps
`include "flash_rst_cfg.svh"

module flash_rst_param_read_tb_top;
  import flash_rst_pkg::*;
  localparam int RP = 8;
  localparam int POR = 20;
  localparam int RECOV[7] = '{24, 26, 32, 28, 30, 36, 40};
  logic clk, rst, cs_n, sclk, si, reset_n, so, so_oe, supply_ok, op_busy;
  logic lock_set, a4b_set, tbl_we, ready, write_enable_latch, write_in_progress, lock, a4b, abort, armed;
  logic [2:0] op_kind;
  logic [7:0] tbl_addr, tbl_data;
  int errors = 0;
  int num_checks = 0;
  int n_abort;

  flash_rst_param_read #(
    .RST_PULSE_CYC(RP), .POR_RECOV_CYC(POR), .DECODE_RECOV_CYC(RECOV[0]),
    .READ_RECOV_CYC(RECOV[1]), .PROG_RECOV_CYC(RECOV[2]), .SE4K_RECOV_CYC(RECOV[3]),
    .BE_RECOV_CYC(RECOV[4]), .CE_RECOV_CYC(RECOV[5]), .STATUS_REG_WRITE_RECOV_CYC(RECOV[6])
  ) u_dut (
    .I_CLK_SYS(clk), .I_RST(rst), .I_CS_N(cs_n), .I_SCLK(sclk), .I_SI(si),
    .I_RESET_N(reset_n), .O_SO(so), .O_SO_OE(so_oe), .I_SUPPLY_OK(supply_ok),
    .I_OP_BUSY(op_busy), .I_OP_KIND(op_kind), .I_SRAM_LOCK_SET(lock_set),
    .I_ADDR_4B_SET(a4b_set), .I_TBL_WE(tbl_we), .I_TBL_ADDR(tbl_addr),
    .I_TBL_DATA(tbl_data), .O_READY(ready), .O_WRITE_ENABLE_LATCH(write_enable_latch),
    .O_WRITE_IN_PROGRESS(write_in_progress), .O_SRAM_LOCK(lock), .O_ADDR_4B(a4b),
    .O_OP_ABORT(abort), .O_SOFT_RESET_ARMED(armed)
  );

  // Released output line reads as the inverse so stale data cannot pass
  spi_host_model u_host (
    .i_clk(clk), .i_so(so_oe ? so : ~so), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si),
    .o_reset_n(reset_n)
  );

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Abort pulse tally
  always @(posedge clk)
    if (abort === 1'b1) n_abort++;

  task automatic stop_test();
    if (errors == 0 && num_checks > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    logic [7:0] rx;
    u_host.sel();
    u_host.xfer(c, rx);
    u_host.desel();
  endtask

  // Bounded wait; ready must come neither early nor late
  task automatic wait_ready(input int lo, input int hi);
    int cnt;
    cnt = 0;
    while (ready !== 1'b1 && cnt < 5000)
    begin
      @(negedge clk);
      cnt++;
    end
    check_bit(cnt >= lo && cnt <= hi, 1'b1);
  endtask

  task automatic read_tbl(input logic [7:0] a, input int n);
    logic [7:0] rx;
    u_host.sel();
    u_host.xfer(`CMD_READ_PARAM_TABLE, rx);
    u_host.xfer(8'h00, rx);
    u_host.xfer(8'h00, rx);
    u_host.xfer(a, rx);
    u_host.xfer(8'hFF, rx);
    for (int i = 0; i < n; i++)
    begin
      u_host.xfer(8'h55, rx);
      check_byte(rx, (a + i[7:0]) ^ 8'h3C);
    end
    check_bit(so_oe, 1'b1);
    u_host.desel();
    check_bit(so_oe, 1'b0);
  endtask

  task automatic full_reset(input int k, input logic busy, input int r);
    op_kind = k[2:0];
    op_busy = busy;
    n_abort = 0;
    repeat (3) @(negedge clk);
    check_bit(write_in_progress, busy);
    u_host.hw_reset(RP + 4);
    op_busy = 1'b0;
    check_bit(n_abort != 0, busy);
    check_bit(write_enable_latch | lock | a4b | write_in_progress, 1'b0);
    wait_ready(r, r + 4);
    u_host.settle();
  endtask

  task automatic set_vol();
    cmd(`CMD_WRITE_ENABLE);
    lock_set = 1'b1;
    a4b_set = 1'b1;
    @(negedge clk);
    lock_set = 1'b0;
    a4b_set = 1'b0;
    @(negedge clk);
    check_bit(write_enable_latch & lock & a4b, 1'b1);
  endtask

  // Watchdog, far beyond the few thousand cycles the run needs
  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    {rst, supply_ok, op_busy, op_kind, lock_set, a4b_set} = {1'b1, 1'b1, 6'h00};
    {tbl_we, tbl_addr, tbl_data} = 17'h00000;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    check_bit(ready, 1'b1);
    check_bit(write_enable_latch, 1'b0);
    for (int a = 0; a < 256; a++)
    begin
      {tbl_we, tbl_addr, tbl_data} = {1'b1, a[7:0], a[7:0] ^ 8'h3C};
      @(negedge clk);
    end
    tbl_we = 1'b0;
    full_reset(0, 1'b0, POR);
    read_tbl(8'h10, 2);
    read_tbl(8'hFE, 3);
    for (int k = 0; k < 7; k++)
    begin
      set_vol();
      full_reset(k, k >= 2, RECOV[k]);
    end
    set_vol();
    u_host.hw_reset(RP - 4);
    check_bit(write_enable_latch & lock, 1'b1);
    u_host.settle();
    // No core operation running, so soft reset recovery is the decode time
    op_kind = 3'h0;
    cmd(`CMD_SOFT_RESET_ARM);
    check_bit(armed, 1'b1);
    cmd(`CMD_SOFT_RESET);
    check_bit(write_enable_latch | lock | a4b | ready | armed, 1'b0);
    wait_ready(RECOV[0] - 9, RECOV[0] - 5);
    cmd(`CMD_SOFT_RESET_ARM);
    cmd(`CMD_WRITE_ENABLE);
    cmd(`CMD_SOFT_RESET);
    check_bit(write_enable_latch & ready & ~armed, 1'b1);
    cmd(`CMD_WRITE_DISABLE);
    check_bit(write_enable_latch, 1'b0);
    supply_ok = 1'b0;
    repeat (2) @(negedge clk);
    check_bit(ready, 1'b0);
    cmd(`CMD_WRITE_ENABLE);
    check_bit(write_enable_latch, 1'b0);
    supply_ok = 1'b1;
    wait_ready(1, 2);
    u_host.settle();
    read_tbl(8'h80, 1);
    stop_test();
  end
endmodule // flash_rst_param_read_tb_top
